/* include/mlp_cfg.svh */
// register map, reset values and timing counts of the matrix led register port
`ifndef MLP_CFG_SVH
`define MLP_CFG_SVH
`define MLP_DEV_ID      5'h0d
`define MLP_DUTY_LO     8'h03
`define MLP_DUTY_HI     8'h8f
`define MLP_SCALE_LO    8'h92
`define MLP_SCALE_HI    8'h9f
`define MLP_OPCFG_ADR   8'ha0
`define MLP_GCL_ADR     8'ha1
`define MLP_RES_ADR     8'hb0
`define MLP_SS_ADR      8'hb1
`define MLP_PWMF_ADR    8'hb2
`define MLP_FLT_LO      8'hb3
`define MLP_FLT_HI      8'hc4
`define MLP_SRST_ADR    8'hcf
`define MLP_OPCFG_RST   8'h10
`define MLP_RES_RST     8'h33
`define MLP_PWMF_RST    8'h01
`define MLP_ZERO_RST    8'h00
`define MLP_CLK_NS      8
`define MLP_SCL_MIN_NS  1000
`define MLP_SCL_HALF_CYC ((`MLP_SCL_MIN_NS / `MLP_CLK_NS) / 2)
`endif

/* include/mlp_pkg.sv */
// types shared by the matrix led register port
package mlp_pkg;
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK_A = 9'h004,
    ST_PTR   = 9'h008,
    ST_ACK_P = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_W = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } mlp_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } mlp_wcmd_s;

  typedef struct packed {
    logic [7:0] op_cfg;
    logic [7:0] gcl;
    logic [7:0] res_sel;
    logic [7:0] spread;
    logic [7:0] pwm_freq;
  } mlp_ctrl_s;
endpackage

/* rtl/mlp_fifo.sv */
// write command fifo with valid/ready on both sides
`timescale 1ns/100ps
module mlp_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign in_ready  = (cnt_q < (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = (AW+1)'(cnt_q + push - pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage needs no reset, the count guards it
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule

/* rtl/mlp_mem.sv */
// register space memory, one write port, one registered read port
`timescale 1ns/100ps
module mlp_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic [DW-1:0]      rdata_q
);
  logic [DW-1:0] arr_q [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      arr_q[waddr] <= wdata;
    end
  end

  // contents are filled by the clearing sweep after every reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= arr_q[raddr];
    end
  end
endmodule

/* rtl/mlp_port.sv */
// two-wire target port and register space of the matrix led driver
`timescale 1ns/100ps
`include "mlp_cfg.svh"
// Operation
// [RULE1] 7-bit bus address then direction bit, 0 write and 1 read.
// [RULE2] address is 01101 plus two strap bits from the address pin.
// [RULE3] data is sampled while clock is high; idle data line is high.
// [RULE4] falling data with clock high is start; compare address next.
// [RULE5] address arrives msb first; on match pull data low for ack.
// [RULE6] controller stops and abandons transfer when address is not acked.
// [RULE7] after write address ack, receive and ack the pointer byte.
// [RULE8] ack each data byte and store it at the pointer. A byte that meets a full fifo is not-acknowledged and dropped.
// [RULE9] rising data with clock high is stop; end the transfer.
// [RULE10] pointer advances by one at each acked data byte.
// [RULE11] read: write pointer, repeated start, read address returns register.
// [RULE12] works at bus clock rates up to 1 MHz.
// [RULE13] per-dot duty registers 03h to 8Fh, read/write, reset zero.
// [RULE14] column scale registers 92h to 9Fh, read/write, reset zero.
// [RULE15] operating configuration register A0h resets to 10h.
// [RULE16] global current level register A1h resets to zero.
// [RULE17] resistor selection register B0h resets to 33h.
// [RULE18] spread spectrum register B1h resets to zero.
// [RULE19] pwm frequency register B2h resets to 01h.
// [RULE20] fault status registers B3h to C4h readable by controller.
// [RULE21] any write to CFh returns every register to reset value.
// [RULE22] unmapped writes acked and dropped, pointer advances; reads give zero.
module mlp_port (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        ad_i,
  output logic             sda_o,
  output logic             sda_oe,
  output mlp_pkg::mlp_ctrl_s ctrl_q,
  output logic             busy_q
);
  localparam int HALF = `MLP_SCL_HALF_CYC;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a >= `MLP_DUTY_LO && a <= `MLP_DUTY_HI)
          || (a >= `MLP_SCALE_LO && a <= `MLP_SCALE_HI)
          || a == `MLP_OPCFG_ADR || a == `MLP_GCL_ADR
          || (a >= `MLP_RES_ADR && a <= `MLP_PWMF_ADR)
          || (a >= `MLP_FLT_LO && a <= `MLP_FLT_HI);
  endfunction

  function automatic logic [7:0] por(input logic [7:0] a);
    case (a)
      `MLP_OPCFG_ADR: por = `MLP_OPCFG_RST; // [RULE15]
      `MLP_RES_ADR:   por = `MLP_RES_RST;   // [RULE17]
      `MLP_PWMF_ADR:  por = `MLP_PWMF_RST;  // [RULE19]
      default:        por = `MLP_ZERO_RST;  // [RULE13] [RULE14] [RULE20]
    endcase
  endfunction

  // pin synchronisers and edge history
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, ad_m, ad_s;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
      // strap history starts at the idle level of both bus lines, so a
      // strap tied to either line never looks different from it
      {ad_m, ad_s}          <= 2'h3;
    end else begin
      {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
      {ad_m, ad_s}          <= {ad_i, ad_m};
    end
  end

  logic scl_rise, scl_fall, start, stop;
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start    = scl_s & scl_p & sda_p & ~sda_s; // [RULE4]
  assign stop     = scl_s & scl_p & ~sda_p & sda_s; // [RULE9]

  // strap: the pin may be tied to a rail or to one of the bus lines,
  // so watch whether it ever goes low or ever disagrees with each line
  logic ad_low_q, ad_low_d, ne_scl_q, ne_scl_d, ne_sda_q, ne_sda_d;
  logic [1:0] strap;
  always_comb begin
    ad_low_d = ad_low_q | ~ad_s;
    ne_scl_d = ne_scl_q | (ad_s ^ scl_s);
    ne_sda_d = ne_sda_q | (ad_s ^ sda_s);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ad_low_q <= 1'b0;
      ne_scl_q <= 1'b0;
      ne_sda_q <= 1'b0;
    end else begin
      ad_low_q <= ad_low_d;
      ne_scl_q <= ne_scl_d;
      ne_sda_q <= ne_sda_d;
    end
  end
  always_comb begin
    if (!ad_low_q)      strap = 2'h3;
    else if (!ne_scl_q) strap = 2'h1;
    else if (!ne_sda_q) strap = 2'h2;
    else                strap = 2'h0;
  end

  // fifo and memory
  mlp_pkg::mlp_wcmd_s push_cmd, drain_cmd;
  logic push, fifo_rdy, drain_vld, drain_rdy, sweep_q;
  logic we;
  logic [7:0] waddr, wdata, rdata;
  logic [7:0] ptr_q, ptr_d;

  mlp_fifo #(.W(16), .D(8)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .in_data   (push_cmd),
    .out_valid (drain_vld),
    .out_ready (drain_rdy),
    .out_data  (drain_cmd)
  );

  mlp_mem #(.AW(8), .DW(8)) u_mem (
    .clk     (clk),
    .rst     (rst),
    .we      (we),
    .waddr   (waddr),
    .wdata   (wdata),
    .raddr   (ptr_q),
    .rdata_q (rdata)
  );

  // transfer state machine, all bus moves happen on synchronised edges
  mlp_pkg::mlp_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d;
  logic       rw_q, rw_d, oe_q, oe_d, nack_q, nack_d, hit;

  assign hit      = sh_q[7:1] == {`MLP_DEV_ID, strap}; // [RULE2]
  assign push_cmd = '{addr: ptr_q, data: sh_q};
  assign push     = scl_fall && st_q == mlp_pkg::ST_WDATA
                    && cnt_q == 4'h8 && fifo_rdy;

  always_comb begin
    st_d = st_q;  cnt_d = cnt_q;  sh_d = sh_q;  tx_d = tx_q;
    rw_d = rw_q;  oe_d = oe_q;  nack_d = nack_q;  ptr_d = ptr_q;
    if (start) begin
      st_d = mlp_pkg::ST_ADDR;  cnt_d = 4'h0;  oe_d = 1'b0; // [RULE4]
    end else if (stop) begin
      st_d = mlp_pkg::ST_IDLE;  oe_d = 1'b0; // [RULE9]
    end else if (scl_rise) begin
      sh_d = {sh_q[6:0], sda_s}; // [RULE3]
      if (cnt_q != 4'h8) cnt_d = 4'(cnt_q + 1'b1);
      if (st_q == mlp_pkg::ST_RACK) nack_d = sda_s;
    end else if (scl_fall) begin
      case (st_q)
        mlp_pkg::ST_ADDR: begin
          if (cnt_q == 4'h8) begin
            if (hit) begin
              st_d = mlp_pkg::ST_ACK_A;  oe_d = 1'b1; // [RULE5]
              rw_d = sh_q[0]; // [RULE1]
            end else begin
              st_d = mlp_pkg::ST_IDLE;
            end
          end
        end
        mlp_pkg::ST_ACK_A: begin
          cnt_d = 4'h0;
          if (rw_q) begin
            st_d = mlp_pkg::ST_RDATA;  tx_d = rdata; // [RULE11]
            oe_d = ~rdata[7];
          end else begin
            st_d = mlp_pkg::ST_PTR;  oe_d = 1'b0;
          end
        end
        mlp_pkg::ST_PTR: begin
          if (cnt_q == 4'h8) begin
            ptr_d = sh_q;  st_d = mlp_pkg::ST_ACK_P;  oe_d = 1'b1; // [RULE7]
          end
        end
        mlp_pkg::ST_WDATA: begin
          if (cnt_q == 4'h8) begin
            st_d = mlp_pkg::ST_ACK_W;
            // a full fifo refuses the byte with a not-acknowledge
            oe_d = fifo_rdy; // [RULE8] [RULE22]
            if (fifo_rdy) ptr_d = 8'(ptr_q + 1'b1); // [RULE10]
          end
        end
        mlp_pkg::ST_ACK_P, mlp_pkg::ST_ACK_W: begin
          st_d = mlp_pkg::ST_WDATA;  cnt_d = 4'h0;  oe_d = 1'b0;
        end
        mlp_pkg::ST_RDATA: begin
          if (cnt_q == 4'h8) begin
            st_d = mlp_pkg::ST_RACK;  oe_d = 1'b0;
            ptr_d = 8'(ptr_q + 1'b1);
          end else begin
            tx_d = {tx_q[6:0], 1'b0};  oe_d = ~tx_q[6];
          end
        end
        mlp_pkg::ST_RACK: begin
          cnt_d = 4'h0;
          if (nack_q) begin
            st_d = mlp_pkg::ST_IDLE;
          end else begin
            st_d = mlp_pkg::ST_RDATA;  tx_d = rdata;  oe_d = ~rdata[7];
          end
        end
        default: begin
          st_d = mlp_pkg::ST_IDLE;  oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= mlp_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      nack_q <= 1'b0;
      ptr_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      rw_q <= rw_d;
      oe_q <= oe_d;
      nack_q <= nack_d;
      ptr_q <= ptr_d;
    end
  end

  // open drain: the pin is only ever pulled low
  assign sda_o  = 1'b0;
  assign sda_oe = oe_q;

  // drain and clearing sweep; reads in the 256 sweep cycles see old data at addresses not yet swept
  logic [7:0] clr_q, clr_d;
  logic       sweep_d, srst_hit;
  mlp_pkg::mlp_ctrl_s ctrl_d;
  assign drain_rdy = ~sweep_q;
  assign srst_hit  = drain_vld && drain_rdy
                     && drain_cmd.addr == `MLP_SRST_ADR;

  always_comb begin
    sweep_d = sweep_q;
    clr_d   = clr_q;
    ctrl_d  = ctrl_q;
    we      = 1'b0;
    waddr   = drain_cmd.addr;
    wdata   = drain_cmd.data;
    if (sweep_q) begin
      we    = 1'b1;
      waddr = clr_q;
      wdata = por(clr_q);
      clr_d = 8'(clr_q + 1'b1);
      if (clr_q == 8'hff) sweep_d = 1'b0;
      ctrl_d = '{op_cfg: `MLP_OPCFG_RST, gcl: `MLP_ZERO_RST,
                 res_sel: `MLP_RES_RST, spread: `MLP_ZERO_RST,
                 pwm_freq: `MLP_PWMF_RST}; // [RULE15] [RULE16] [RULE18]
    end else if (srst_hit) begin
      sweep_d = 1'b1; // [RULE21]
      clr_d   = 8'h00;
    end else if (drain_vld) begin
      we = mapped(drain_cmd.addr); // [RULE22]
      case (drain_cmd.addr)
        `MLP_OPCFG_ADR: ctrl_d.op_cfg   = drain_cmd.data;
        `MLP_GCL_ADR:   ctrl_d.gcl      = drain_cmd.data;
        `MLP_RES_ADR:   ctrl_d.res_sel  = drain_cmd.data;
        `MLP_SS_ADR:    ctrl_d.spread   = drain_cmd.data;
        `MLP_PWMF_ADR:  ctrl_d.pwm_freq = drain_cmd.data;
        default:        ctrl_d          = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sweep_q <= 1'b1;
      clr_q   <= 8'h00;
      ctrl_q  <= '{op_cfg: `MLP_OPCFG_RST, gcl: `MLP_ZERO_RST,
                   res_sel: `MLP_RES_RST, spread: `MLP_ZERO_RST,
                   pwm_freq: `MLP_PWMF_RST};
      busy_q  <= 1'b1;
    end else begin
      sweep_q <= sweep_d;
      clr_q   <= clr_d;
      ctrl_q  <= ctrl_d;
      busy_q  <= sweep_d;
    end
  end

  // checks
  addr_ack_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
    scl_fall && st_q == mlp_pkg::ST_ADDR && cnt_q == 4'h8 && hit
    |=> sda_oe && st_q == mlp_pkg::ST_ACK_A)
    else $error("matching address not acknowledged");
  addr_miss_a: assert property (@(posedge clk) disable iff (rst) // [RULE2]
    scl_fall && st_q == mlp_pkg::ST_ADDR && cnt_q == 4'h8 && !hit
    |=> !sda_oe && st_q == mlp_pkg::ST_IDLE)
    else $error("foreign address acknowledged");
  ptr_load_a: assert property (@(posedge clk) disable iff (rst) // [RULE7]
    scl_fall && st_q == mlp_pkg::ST_PTR && cnt_q == 4'h8
    |=> ptr_q == $past(sh_q) && sda_oe)
    else $error("pointer byte not loaded");
  data_push_a: assert property (@(posedge clk) disable iff (rst) // [RULE8]
    push |=> (sda_oe && st_q == mlp_pkg::ST_ACK_W) [*2])
    else $error("data byte not stored or acked");
  ptr_step_a: assert property (@(posedge clk) disable iff (rst) // [RULE10]
    push |=> ptr_q == 8'($past(ptr_q) + 1'b1))
    else $error("pointer did not advance");
  stop_end_a: assert property (@(posedge clk) disable iff (rst) // [RULE9]
    stop |=> st_q == mlp_pkg::ST_IDLE && !sda_oe)
    else $error("stop did not end transfer");
  start_go_a: assert property (@(posedge clk) disable iff (rst) // [RULE4]
    start |=> st_q == mlp_pkg::ST_ADDR && cnt_q == 4'h0)
    else $error("start did not begin address phase");
  sample_high_a: assert property (@(posedge clk) disable iff (rst) // [RULE3]
    sh_q != $past(sh_q) |-> $past(scl_rise))
    else $error("data sampled off the clock rise");
  read_load_a: assert property (@(posedge clk) disable iff (rst) // [RULE11]
    scl_fall && st_q == mlp_pkg::ST_ACK_A && rw_q && !start && !stop
    |=> tx_q == $past(rdata) && sda_oe == !$past(rdata[7]))
    else $error("read byte not loaded from register");
  soft_rst_a: assert property (@(posedge clk) disable iff (rst) // [RULE21]
    srst_hit |=> sweep_q [*8] ##1 ctrl_q.op_cfg == `MLP_OPCFG_RST)
    else $error("soft reset did not restore registers");
  unmapped_a: assert property (@(posedge clk) disable iff (rst) // [RULE22]
    we && !sweep_q |-> !(waddr inside {[8'h00:8'h02], [8'h90:8'h91],
                                       [8'ha2:8'haf], [8'hc5:8'hff]}))
    else $error("unmapped location written");
  sweep_done_a: assert property (@(posedge clk) disable iff (rst) // [RULE19]
    $fell(sweep_q) |-> ctrl_q.pwm_freq == `MLP_PWMF_RST
    && ctrl_q.res_sel == `MLP_RES_RST && ctrl_q.gcl == `MLP_ZERO_RST)
    else $error("control registers not at reset values");
  drain_fast_a: assert property (@(posedge clk) disable iff (rst) // [RULE12]
    push && !sweep_q |-> ##[1:HALF] !drain_vld)
    else $error("fifo slower than bus byte rate");

  write_cv: cover property (@(posedge clk) disable iff (rst) push);
  read_cv: cover property (@(posedge clk) disable iff (rst)
    st_q == mlp_pkg::ST_RACK && scl_fall && !nack_q);
  restart_cv: cover property (@(posedge clk) disable iff (rst)
    start && st_q != mlp_pkg::ST_IDLE);
  srst_cv: cover property (@(posedge clk) disable iff (rst) srst_hit);
endmodule

/* tb/mlp_ctl_model.sv */
// two-wire bus controller model that talks to the matrix led register port
`timescale 1ns/100ps
module mlp_ctl_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // a bus bit lasts four quarters of two clk, 64 ns; far faster than the
  // 1 MHz ceiling, so the synchroniser margins are worked hard
  localparam int Q = 2;

  initial begin
    // clock and data both rest high between frames
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // rep brings the clock back high first for a repeated start
  task automatic start_c(input logic rep);
    if (rep) begin
      sda_low <= 1'b0;
      tick(Q);
      scl <= 1'b1;
      tick(Q);
    end
    sda_low <= 1'b1; // data falls while clock high
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask

  task automatic stop_c();
    sda_low <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_low <= 1'b0; // data rises while clock high
    tick(2 * Q);
  endtask

  // b = 1 releases the line, so reading a bit is sending a one
  task automatic bit_x(input logic b, output logic r);
    sda_low <= ~b; // data only moves while the clock is low
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    r = sda;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask

  task automatic byte_x(input logic [7:0] b, input logic ab,
                        output logic [7:0] r, output logic ar);
    for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]); // msb first
    bit_x(ab, ar);
  endtask
endmodule

/* tb/matrix_led_i2c_register_port_tb_top.sv */
// self-checking bench of the matrix led register port
`timescale 1ns/100ps
`define CHK(a, b) begin \
  checked++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); \
  end \
end
module matrix_led_i2c_register_port_tb_top;
  logic               clk;
  logic               rst;
  logic [1:0]         ad_sel;
  logic               scl;
  logic               ctl_low;
  logic               sda_oe;
  logic               sda_o;
  logic               busy;
  mlp_pkg::mlp_ctrl_s ctrl;
  int                 fails;
  int                 checked;
  // open drain with pull-up: any party pulling wins
  wire sda = !(sda_oe && !sda_o) && !ctl_low;
  // strap code equals ad_sel: ground, clock wire, data wire, supply
  wire ad = (ad_sel == 2'h0) ? 1'b0 : (ad_sel == 2'h1) ? scl :
            (ad_sel == 2'h2) ? sda : 1'b1;

  mlp_port u_dut (
    .clk    (clk),
    .rst    (rst),
    .scl_i  (scl),
    .sda_i  (sda),
    .ad_i   (ad),
    .sda_o  (sda_o),
    .sda_oe (sda_oe),
    .ctrl_q (ctrl),
    .busy_q (busy)
  );

  mlp_ctl_model u_ctl (
    .clk     (clk),
    .sda     (sda),
    .scl     (scl),
    .sda_low (ctl_low)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop();
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n == 2000) begin
      fails++;
      report_and_stop();
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wait_idle();
  endtask

  task automatic send(input logic [7:0] b);
    logic [7:0] r;
    logic       a;
    u_ctl.byte_x(b, 1'b1, r, a);
    `CHK(a, 1'b0)
  endtask

  task automatic open_ptr(input logic [7:0] p);
    u_ctl.start_c(1'b0);
    send({5'h0d, ad_sel, 1'b0});
    send(p);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    open_ptr(p);
    foreach (d[i]) send(d[i]);
    u_ctl.stop_c();
  endtask

  // last byte is refused by the controller so the target lets go
  task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
    logic [7:0] r;
    logic       a;
    open_ptr(p);
    u_ctl.start_c(1'b1);
    send({5'h0d, ad_sel, 1'b1});
    foreach (e[i]) begin
      u_ctl.byte_x(8'hff, i == e.size() - 1, r, a);
      `CHK(r, e[i])
    end
    u_ctl.stop_c();
  endtask

  task automatic probe(input logic [6:0] adr, input logic exp);
    logic [7:0] r;
    logic       a;
    u_ctl.start_c(1'b0);
    u_ctl.byte_x({adr, 1'b0}, 1'b1, r, a);
    `CHK(a, exp)
    u_ctl.stop_c();
  endtask

  task automatic sc_reset_values();
    `CHK(ctrl, 40'h1000330001)
    rd(8'ha0, '{8'h10, 8'h00, 8'h00});
    rd(8'hb0, '{8'h33, 8'h00, 8'h01, 8'h00});
    rd(8'h02, '{8'h00, 8'h00});
    rd(8'h9f, '{8'h00});
  endtask

  // each strap setting must take its own address and refuse neighbours
  task automatic sc_strap();
    for (int s = 0; s < 4; s++) begin
      ad_sel <= s[1:0];
      do_reset();
      probe({5'h0d, s[1:0]}, 1'b0);
      probe({5'h0d, s[1:0] ^ 2'h1}, 1'b1);
      probe({5'h0c, s[1:0]}, 1'b1);
    end
  endtask

  // burst crosses from the duty block through a gap into the scale block
  task automatic sc_burst();
    wr(8'h8e, '{8'ha5, 8'h5a, 8'h11, 8'h22, 8'hc3});
    rd(8'h8e, '{8'ha5, 8'h5a, 8'h00, 8'h00, 8'hc3});
    wr(8'ha0, '{8'h81, 8'h7f});
    `CHK(ctrl.op_cfg, 8'h81)
    `CHK(ctrl.gcl, 8'h7f)
    wr(8'hb0, '{8'hc4, 8'h1d, 8'h05, 8'h5e});
    `CHK(ctrl, 40'h817fc41d05)
    rd(8'hb3, '{8'h5e});
  endtask

  task automatic sc_soft_reset();
    wr(8'hcf, '{8'h00});
    `CHK(busy, 1'b1)
    wait_idle();
    `CHK(ctrl, 40'h1000330001)
    rd(8'h8e, '{8'h00, 8'h00});
    rd(8'hcf, '{8'h00});
  endtask

  initial begin
    rst = 1'b1;
    ad_sel = 2'h3;
    fails = 0;
    checked = 0;
    do_reset();
    sc_reset_values();
    sc_strap();
    sc_burst();
    sc_soft_reset();
    report_and_stop();
  end
endmodule
